// ==== rtl/flash_seq_map.svh ====
// Constants for the flash command sequencer: command codes, address field
// positions, operation codes and reset values.
// Assumes a single-data-rate memory bus with separate address and data pins.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// Commands as {cs_n, ras_n, cas_n, we_n}.
`define CMD_DESEL 4'hf
`define CMD_NOP 4'h7
`define CMD_LOAD_CMD 4'h0
`define CMD_ACTIVATE 4'h3
`define CMD_READ 4'h5
`define CMD_WRITE 4'h4
`define CMD_PRECHARGE 4'h2
`define CMD_REFRESH 4'h1

// Operation codes placed on the low address byte by a load command.
`define OP_WRITE_SETUP 8'h40
`define OP_READ_STATUS 8'h70

// Host word address layout.
`define HADDR_W 25
`define FLASH_BIT 24
`define BANK_HI 23
`define BANK_LO 22
`define ROW_HI 21
`define ROW_LO 10
`define COL_HI 9
`define COL_LO 0

// Memory address bit that selects auto precharge or precharge-all.
`define AP_BIT 10

// Smallest CAS latency honoured; a setting of zero is raised to this.
`define CL_MIN 4'h1

// Reset values.
`define RST_ADDR 12'h000
`define RST_BANK 2'h0
`define RST_DATA 16'h0000

`endif

// ==== rtl/flash_seq_pkg.sv ====
// Types for the flash command sequencer.
// Assumes the constants header is compiled alongside.
`default_nettype none

package flash_seq_pkg;

  // One-hot sequencer states.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LCMD = 6'h02,
    ST_ACT = 6'h04,
    ST_XFER = 6'h08,
    ST_PRE = 6'h10,
    ST_REF = 6'h20
  } seq_state_t;

  // Whole register state of the sequencer.
  typedef struct packed {
    seq_state_t st;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [11:0] a;
    logic [15:0] dq_out;
    logic dq_oe;
    logic ack;
    logic [15:0] rdata;
    logic ref_ack;
    logic busy;
  } seq_regs_t;

  // State of the down-counting wait timer.
  typedef struct packed {
    logic [3:0] cnt;
  } timer_regs_t;

endpackage

`default_nettype wire

// ==== rtl/wait_timer.sv ====
// Down-counting cycle timer used for every programmable spacing.
// Assumes the owner loads it in the cycle that a timed command is issued.
`timescale 1ns/100ps
`default_nettype none

module wait_timer #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic expired
);

  // Current count; reaching zero ends the wait.
  flash_seq_pkg::timer_regs_t q;
  flash_seq_pkg::timer_regs_t d;

  // Expiry is combinational so the owner can act in the same cycle.
  assign expired = (q.cnt == 4'h0);

  // A load wins over counting; the count parks at zero.
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = value;
    end else if (q.cnt != 4'h0) begin
      d.cnt = q.cnt - 4'h1;
    end
  end

  // Synchronous reset leaves the timer already expired.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/flash_cmd_seq.sv ====
// Flash command sequencer: turns flash accesses into command triplets and plain accesses into pairs on a
// synchronous memory bus, and runs precharge plus refresh on request.
// Assumes the host holds its request and address steady until acknowledged,
// and that the memory bus pins are registered in the pad ring unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"

module flash_cmd_seq (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [`HADDR_W-1:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic host_ack,
  output logic [15:0] host_rdata,
  input wire logic refresh_req,
  output logic refresh_ack,
  input wire logic [1:0] cas_lat,
  input wire logic [3:0] trcd,
  input wire logic [3:0] trc,
  output logic busy,
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n,
  output logic [1:0] sd_ba,
  output logic [11:0] sd_a,
  input wire logic [15:0] sd_dq_in,
  output logic [15:0] sd_dq_out,
  output logic sd_dq_oe
);

  // Registered state and its next value.
  flash_seq_pkg::seq_regs_t q;
  flash_seq_pkg::seq_regs_t d;

  // Timer control and status.
  logic tmr_load;
  logic [3:0] tmr_val;
  logic tmr_done;

  // Address fields of the pending host access.
  logic in_flash;
  logic [1:0] h_bank;
  logic [11:0] h_row;
  logic [9:0] h_col;

  // Spacing settings reduced to wait counts.
  logic [3:0] rcd_wait;
  logic [3:0] rc_wait;
  logic [3:0] cl_wait;

  assign in_flash = host_addr[`FLASH_BIT];
  assign h_bank = host_addr[`BANK_HI:`BANK_LO];
  assign h_row = host_addr[`ROW_HI:`ROW_LO];
  assign h_col = host_addr[`COL_HI:`COL_LO];

  // A setting of zero would mean no gap at all, so it acts as one cycle.
  assign rcd_wait = (trcd == 4'h0) ? 4'h0 : trcd - 4'h1;
  assign rc_wait = (trc == 4'h0) ? 4'h0 : trc - 4'h1;
  // Latency zero is not a legal memory setting; it is raised to one.
  assign cl_wait = (cas_lat == 2'h0) ? `CL_MIN : {2'h0, cas_lat};

  // One timer serves row-to-column, row-cycle and CAS latency waits,
  // which never overlap because only one sequence runs at a time.
  wait_timer #(
    .W(4)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(tmr_load),
    .value(tmr_val),
    .expired(tmr_done)
  );

  // Next-state logic. The state names the command that is on the pins in
  // its first cycle; every later cycle of the same state shows a no-op, so
  // each command is exactly one clock wide.
  always_comb begin
    d = q;
    d.cmd = `CMD_NOP;
    d.dq_oe = 1'b0;
    d.ack = 1'b0;
    d.ref_ack = 1'b0;
    tmr_load = 1'b0;
    tmr_val = 4'h0;
    case (q.st)
      // Refresh is served first so that a stream of host traffic can not
      // starve it. The acknowledge guards stop a held request restarting.
      flash_seq_pkg::ST_IDLE: begin
        if (refresh_req && !q.ref_ack) begin
          // Precharge all banks ahead of the refresh.
          d.st = flash_seq_pkg::ST_PRE;
          d.cmd = `CMD_PRECHARGE;
          d.a = `RST_ADDR;
          d.a[`AP_BIT] = 1'b1;
          tmr_load = 1'b1;
          tmr_val = rc_wait;
        end else if (host_req && !q.ack) begin
          if (in_flash) begin
            // Flash access opens with a load command carrying the opcode
            // in the low byte and the bank plus the top four row bits on the rest.
            d.st = flash_seq_pkg::ST_LCMD;
            d.cmd = `CMD_LOAD_CMD;
            d.ba = h_bank;
            d.a[11:8] = h_row[11:8];
            if (host_we) begin
              d.a[7:0] = `OP_WRITE_SETUP;
            end else begin
              d.a[7:0] = `OP_READ_STATUS;
            end
          end else begin
            // Plain memory access skips the load command.
            d.st = flash_seq_pkg::ST_ACT;
            d.cmd = `CMD_ACTIVATE;
            d.ba = h_bank;
            d.a = h_row;
            tmr_load = 1'b1;
            tmr_val = rcd_wait;
          end
        end
      end
      // Second command of the triplet: activate with row and bank.
      flash_seq_pkg::ST_LCMD: begin
        d.st = flash_seq_pkg::ST_ACT;
        d.cmd = `CMD_ACTIVATE;
        d.ba = h_bank;
        d.a = h_row;
        tmr_load = 1'b1;
        tmr_val = rcd_wait;
      end
      // Hold no-ops until the row-to-column delay has run out.
      flash_seq_pkg::ST_ACT: begin
        if (tmr_done) begin
          d.st = flash_seq_pkg::ST_XFER;
          d.ba = h_bank;
          // Plain memory closes its row by auto precharge; flash does not
          // take that bit, so it stays low there.
          d.a = {1'b0, !in_flash, h_col};
          if (host_we) begin
            // Single data word; no burst follows, so no terminate command.
            d.cmd = `CMD_WRITE;
            d.dq_out = host_wdata;
            d.dq_oe = 1'b1;
          end else begin
            d.cmd = `CMD_READ;
            tmr_load = 1'b1;
            tmr_val = cl_wait;
          end
        end
      end
      // Write ends here; a read waits out the CAS latency, then samples.
      flash_seq_pkg::ST_XFER: begin
        if (host_we) begin
          d.st = flash_seq_pkg::ST_IDLE;
          d.ack = 1'b1;
        end else if (tmr_done) begin
          d.st = flash_seq_pkg::ST_IDLE;
          d.ack = 1'b1;
          if (in_flash) begin
            // Status sits on the low byte only; upper lines are ignored.
            d.rdata = {8'h00, sd_dq_in[7:0]};
          end else begin
            d.rdata = sd_dq_in;
          end
        end
      end
      // After the precharge, space the refresh by the row-cycle time.
      flash_seq_pkg::ST_PRE: begin
        if (tmr_done) begin
          d.st = flash_seq_pkg::ST_REF;
          d.cmd = `CMD_REFRESH;
          tmr_load = 1'b1;
          tmr_val = rc_wait;
        end
      end
      // The row-cycle time also runs after the refresh before any command.
      flash_seq_pkg::ST_REF: begin
        if (tmr_done) begin
          d.st = flash_seq_pkg::ST_IDLE;
          d.ref_ack = 1'b1;
        end
      end
      // An illegal code returns quietly to idle.
      default: begin
        d.st = flash_seq_pkg::ST_IDLE;
      end
    endcase
    // Busy marks a sequence in flight; nothing else can start meanwhile.
    d.busy = (d.st != flash_seq_pkg::ST_IDLE);
  end

  // State register with synchronous reset; the bus is deselected in reset.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q.st <= flash_seq_pkg::ST_IDLE;
      q.cmd <= `CMD_DESEL;
      q.ba <= `RST_BANK;
      q.a <= `RST_ADDR;
      q.dq_out <= `RST_DATA;
      q.dq_oe <= 1'b0;
      q.ack <= 1'b0;
      q.rdata <= `RST_DATA;
      q.ref_ack <= 1'b0;
      q.busy <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from the state register.
  assign sd_cs_n = q.cmd[3];
  assign sd_ras_n = q.cmd[2];
  assign sd_cas_n = q.cmd[1];
  assign sd_we_n = q.cmd[0];
  assign sd_ba = q.ba;
  assign sd_a = q.a;
  assign sd_dq_out = q.dq_out;
  assign sd_dq_oe = q.dq_oe;
  assign host_ack = q.ack;
  assign host_rdata = q.rdata;
  assign refresh_ack = q.ref_ack;
  assign busy = q.busy;

endmodule

`default_nettype wire

// ==== verif/flash_mem_model.sv ====
// Memory model: answers read commands with a status byte.
// Assumes the bench sets the status value before each read.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_mem_model (
  input wire logic mclk,
  input wire logic [3:0] cmd,
  input wire logic [1:0] cas_lat,
  input wire logic [7:0] status,
  output logic [15:0] dq
);
  // Reads in flight, one bit per cycle since the command was latched.
  logic [2:0] p = 3'h0;
  logic [2:0] np;
  logic [1:0] cl;
  // Data lines as the memory holds them; one process owns them.
  logic [15:0] dq_q = 16'h5a5a;
  // Latency zero is treated as one, as the sequencer does.
  assign cl = (cas_lat == 2'h0) ? 2'h1 : cas_lat;
  assign np = {p[1:0], cmd == `CMD_READ};
  assign dq = dq_q;
  // Outside the data cycle the lines toggle, so stale data never matches.
  always @(posedge mclk) begin
    p <= np;
    if (np[cl - 2'h1]) begin
      dq_q <= {~status, status};
    end else begin
      dq_q <= ~dq_q;
    end
  end
endmodule
`default_nettype wire

// ==== verif/flash_cmd_seq_monitor.sv ====
// Checker on the sequencer's command pins.
// Assumes cas_lat, trcd and trc stay steady while a sequence runs.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module flash_cmd_seq_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_ack,
  input wire logic busy,
  input wire logic [1:0] cas_lat,
  input wire logic [3:0] trcd,
  input wire logic [3:0] trc,
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  input wire logic [1:0] sd_ba,
  input wire logic sd_dq_oe
);
  // Command now on the pins.
  logic [3:0] c;
  assign c = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  load_act_a: assert property (
    c == `CMD_LOAD_CMD |=> c == `CMD_ACTIVATE && $stable(sd_ba)) else $error("no act");
  load_busy_a: assert property (
    c == `CMD_LOAD_CMD |-> busy) else $error("idle in load");
  oe_write_a: assert property (
    sd_dq_oe |-> c == `CMD_WRITE) else $error("oe off write");
  no_burst_a: assert property (
    c == `CMD_WRITE |=> c == `CMD_NOP && host_ack) else $error("write tail");
  rcd_one_a: assert property (
    c == `CMD_ACTIVATE && trcd < 4'h2 |=> c inside {`CMD_READ, `CMD_WRITE})
    else $error("rcd one");
  rcd_two_a: assert property (
    c == `CMD_ACTIVATE && trcd == 4'h2 |=> c == `CMD_NOP ##1 c inside {`CMD_READ, `CMD_WRITE})
    else $error("rcd two");
  rc_three_a: assert property (
    c == `CMD_PRECHARGE && trc == 4'h3 |=> (c == `CMD_NOP) [*2] ##1 c == `CMD_REFRESH)
    else $error("rc three");
  read_lat_a: assert property (
    c == `CMD_READ && cas_lat == 2'h2 |-> ##3 host_ack) else $error("cl two");
endmodule
bind flash_cmd_seq flash_cmd_seq_checker flash_cmd_seq_checker_i (.mclk, .rst_n, .host_ack,
  .busy, .cas_lat, .trcd, .trc, .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_ba, .sd_dq_oe);
`default_nettype wire

// ==== verif/tb_top.sv ====
// Bench for the flash command sequencer with a memory model.
// Assumes the checker is bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "flash_seq_map.svh"
module tb_top;
  logic mclk, rst_n, host_req, host_we, refresh_req, host_ack, refresh_ack, busy;
  logic sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dq_oe;
  logic [24:0] host_addr;
  logic [15:0] host_wdata, host_rdata, sd_dq_in, sd_dq_out;
  logic [1:0] cas_lat, sd_ba;
  logic [3:0] trcd, trc;
  logic [11:0] sd_a;
  logic [7:0] stat;
  int err_count = 0;
  int total_checks = 0;
  flash_cmd_seq flash_cmd_seq_i (.mclk, .rst_n, .host_req, .host_we, .host_addr, .host_wdata,
    .host_ack, .host_rdata, .refresh_req, .refresh_ack, .cas_lat, .trcd, .trc, .busy,
    .sd_cs_n, .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_ba, .sd_a, .sd_dq_in, .sd_dq_out, .sd_dq_oe);
  flash_mem_model flash_mem_model_i (.mclk, .cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}),
    .cas_lat, .status(stat), .dq(sd_dq_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One host access; every command on the pins other than a no-op is judged as it appears.
  task automatic acc(input logic we, input logic [24:0] ad, input logic [15:0] wd);
    logic [11:0] sq;
    logic [3:0] c;
    logic [7:0] op;
    int t, ga, tc;
    sq = 12'hfff;
    ga = 0;
    tc = 0;
    op = we ? `OP_WRITE_SETUP : `OP_READ_STATUS;
    @(posedge mclk);
    host_req <= 1'b1;
    host_we <= we;
    host_addr <= ad;
    host_wdata <= wd;
    for (t = 0; t < 40 && host_ack !== 1'b1; t++) begin
      @(posedge mclk);
      #1;
      c = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
      if (c !== `CMD_NOP) begin
        sq = {sq[7:0], c};
        chk("ba", 16'(ad[23:22]), 16'(sd_ba));
        chk("busy", 16'h1, 16'(busy));
        if (c == `CMD_LOAD_CMD) begin
          chk("op", 16'(op), 16'(sd_a[7:0]));
          chk("ahi", 16'(ad[21:18]), 16'(sd_a[11:8]));
        end else if (c == `CMD_ACTIVATE) begin
          chk("row", 16'(ad[21:10]), 16'(sd_a));
          ga = t;
        end else begin
          chk("col", 16'({~ad[24], ad[9:0]}), 16'(sd_a));
          chk("rcd", 16'((trcd == 4'h0) ? 1 : trcd), 16'(t - ga));
          chk("oe", 16'(we), 16'(sd_dq_oe));
          if (we) chk("wd", wd, sd_dq_out);
          tc = t;
        end
      end
    end
    chk("seq", {4'h0, ad[24] ? 4'h0 : 4'hf, 4'h3, we ? 4'h4 : 4'h5}, 16'(sq));
    chk("ackb", 16'h1, 16'({busy, host_ack}));
    chk("lat", 16'(we ? 1 : ((cas_lat == 2'h0) ? 2 : cas_lat + 1)), 16'(t - 1 - tc));
    if (!we) chk("rd", ad[24] ? {8'h00, stat} : {~stat, stat}, host_rdata);
    @(posedge mclk);
    host_req <= 1'b0;
  endtask
  // Refresh pair; the precharge to refresh gap is measured.
  task automatic refr();
    int t, tp;
    tp = 0;
    @(posedge mclk);
    refresh_req <= 1'b1;
    for (t = 0; t < 40 && refresh_ack !== 1'b1; t++) begin
      @(posedge mclk);
      #1;
      if ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} == `CMD_PRECHARGE) tp = t;
      if ({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} == `CMD_REFRESH) begin
        chk("rc", 16'(trc), 16'(t - tp));
      end
    end
    chk("rack", 16'h1, 16'(refresh_ack));
    @(posedge mclk);
    refresh_req <= 1'b0;
  endtask
  // Mid-run reset while idle: the bus falls back to deselect with every
  // output cleared, and the first command after release is a no-op.
  task automatic rst_chk();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("rcmd", 16'(`CMD_DESEL), 16'({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}));
    chk("rflags", 16'h0, 16'({busy, host_ack, refresh_ack, sd_dq_oe}));
    chk("raddr", 16'h0, 16'({sd_ba, sd_a}));
    chk("rdout", 16'h0, sd_dq_out);
    chk("rdata", 16'h0, host_rdata);
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("rnop", 16'(`CMD_NOP), 16'({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}));
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    test_done();
  end
  // Writes back to back, reads at every latency setting, refresh, then a
  // mid-run reset followed by one more flash read.
  initial begin
    {rst_n, host_req, host_we, refresh_req} = 4'h0;
    {host_addr, host_wdata, stat} = 49'h0;
    {cas_lat, trcd, trc} = 10'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    trcd <= 4'h2;
    acc(1'b1, 25'h1a5c3e7, 16'hc35a);
    acc(1'b1, 25'h0b1f04c, 16'h3ca5);
    trcd <= 4'h1;
    for (int i = 0; i < 4; i++) begin
      cas_lat <= 2'(i);
      stat <= 8'h81 + 8'(i);
      acc(1'b0, 25'h1d2e9b1, 16'h0000);
    end
    acc(1'b0, 25'h0b1f04c, 16'h0000);
    trc <= 4'h3;
    refr();
    rst_chk();
    acc(1'b0, 25'h1d2e9b1, 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
